// file: core/cpd_pkg.sv
// Summary of operation
// RQ1: Subtract puts accumulator minus operand into the accumulator; opcodes a0 b0 c0 d0 e0 f0.
// RQ2: Subtract takes 2,3,4,5,4,3 cycles by mode and changes only negative, zero and carry.
// RQ3: Trap 83 takes 10 cycles, pushes pc low, pc high, index, acc, flags, then masks and vectors.
// RQ4: Opcode 97 copies the accumulator into the index register in 2 cycles, flags untouched.
// RQ5: Opcode 9f copies the index register into the accumulator in 2 cycles, flags untouched.
// RQ6: Test computes operand minus zero without storing it; 3d 4d 5d 6d 7d take 4,3,3,5,4 cycles.
// RQ7: Word-offset indexed mode fetches offset high then low and adds the index register.
// RQ8: Byte-offset indexed mode fetches one offset byte and adds the index register.
// RQ9: Full-address mode fetches the operand address high byte first, then low byte.
// RQ10: Plain indexed mode uses the index register as the address and fetches no address byte.
// RQ11: Bit-test-and-branch fetches the direct address byte, then the branch offset byte.
// RQ12: A relative branch adds its one offset byte to the program counter.
// RQ13: The operand field after an opcode is zero, one or two bytes depending on the mode.
package cpd_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cpd_bus_t;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cpd_flags_t;

    typedef enum logic [3:0] {
        MD_INH, MD_LITERAL_OPERAND, MD_DIR, MD_FULL_ADDRESS, MD_INDEXED_WORD_OFFSET,
        MD_INDEXED_BYTE_OFFSET, MD_INDEXED_PLAIN, MD_REL, MD_BTB, MD_TRAP, MD_NONE
    } cpd_mode_t;

    localparam logic [7:0] OP_SUB_LITERAL = 8'ha0;
    localparam logic [7:0] OP_SUB_DIR = 8'hb0;
    localparam logic [7:0] OP_SUB_FULL = 8'hc0;
    localparam logic [7:0] OP_SUB_WORD_OFS = 8'hd0;
    localparam logic [7:0] OP_SUB_BYTE_OFS = 8'he0;
    localparam logic [7:0] OP_SUB_PLAIN = 8'hf0;
    localparam logic [7:0] OP_TRAP = 8'h83;
    localparam logic [7:0] OP_ACC_TO_IDX = 8'h97;
    localparam logic [7:0] OP_IDX_TO_ACC = 8'h9f;
    localparam logic [7:0] OP_TEST_DIR = 8'h3d;
    localparam logic [7:0] OP_TEST_ACC = 8'h4d;
    localparam logic [7:0] OP_TEST_IDX = 8'h5d;
    localparam logic [7:0] OP_TEST_BYTE_OFS = 8'h6d;
    localparam logic [7:0] OP_TEST_PLAIN = 8'h7d;
    localparam logic [3:0] OP_BTB_HI = 4'h0;
    localparam logic [7:0] OP_BRANCH = 8'h20;

    localparam logic [3:0] CYC_SUB_LITERAL = 4'h2;
    localparam logic [3:0] CYC_SUB_DIR = 4'h3;
    localparam logic [3:0] CYC_SUB_FULL = 4'h4;
    localparam logic [3:0] CYC_SUB_WORD_OFS = 4'h5;
    localparam logic [3:0] CYC_SUB_BYTE_OFS = 4'h4;
    localparam logic [3:0] CYC_SUB_PLAIN = 4'h3;
    localparam logic [3:0] CYC_TRAP = 4'ha;
    localparam logic [3:0] CYC_XFER = 4'h2;
    localparam logic [3:0] CYC_TEST_DIR = 4'h4;
    localparam logic [3:0] CYC_TEST_REG = 4'h3;
    localparam logic [3:0] CYC_TEST_BYTE_OFS = 4'h5;
    localparam logic [3:0] CYC_TEST_PLAIN = 4'h4;
    localparam logic [3:0] CYC_BTB = 4'h5;
    localparam logic [3:0] CYC_BRANCH = 4'h3;
    localparam logic [3:0] CYC_OTHER = 4'h2;

    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SP_RESET = 8'hff;
    localparam logic [4:0] FLAGS_RESET = 5'h08;
    localparam logic [7:0] STACK_PAGE = 8'h00;
    localparam logic [7:0] ZERO_PAGE = 8'h00;
    localparam logic [15:0] TRAP_VEC_HI = 16'hfffc;
    localparam logic [15:0] TRAP_VEC_LO = 16'hfffd;
    localparam logic [2:0] FLAG_PAD = 3'h7;
    localparam logic [2:0] PUSH_LAST = 3'h5;

    // operand field length follows from the mode alone
    function automatic cpd_mode_t mode_of(input logic [7:0] op);
        cpd_mode_t m;
        m = MD_NONE;
        if (op[3:0] == 4'h0 && op[7:4] >= 4'ha) begin
            unique case (op[7:4])
                4'ha: m = MD_LITERAL_OPERAND;
                4'hb: m = MD_DIR;
                4'hc: m = MD_FULL_ADDRESS;
                4'hd: m = MD_INDEXED_WORD_OFFSET;
                4'he: m = MD_INDEXED_BYTE_OFFSET;
                default: m = MD_INDEXED_PLAIN;
            endcase
        end else if (op == OP_TEST_DIR) m = MD_DIR;
        else if (op == OP_TEST_BYTE_OFS) m = MD_INDEXED_BYTE_OFFSET;
        else if (op == OP_TEST_PLAIN) m = MD_INDEXED_PLAIN;
        else if (op == OP_TEST_ACC || op == OP_TEST_IDX) m = MD_INH;
        else if (op == OP_ACC_TO_IDX || op == OP_IDX_TO_ACC) m = MD_INH;
        else if (op == OP_TRAP) m = MD_TRAP;
        else if (op == OP_BRANCH) m = MD_REL;
        else if (op[7:4] == OP_BTB_HI) m = MD_BTB;
        return m;
    endfunction

    function automatic logic [3:0] cycles_of(input logic [7:0] op);
        logic [3:0] n;
        n = CYC_OTHER;
        unique case (op)
            OP_SUB_LITERAL: n = CYC_SUB_LITERAL;
            OP_SUB_DIR: n = CYC_SUB_DIR;
            OP_SUB_FULL: n = CYC_SUB_FULL;
            OP_SUB_WORD_OFS: n = CYC_SUB_WORD_OFS;
            OP_SUB_BYTE_OFS: n = CYC_SUB_BYTE_OFS;
            OP_SUB_PLAIN: n = CYC_SUB_PLAIN;
            OP_TRAP: n = CYC_TRAP;
            OP_ACC_TO_IDX, OP_IDX_TO_ACC: n = CYC_XFER;
            OP_TEST_DIR: n = CYC_TEST_DIR;
            OP_TEST_ACC, OP_TEST_IDX: n = CYC_TEST_REG;
            OP_TEST_BYTE_OFS: n = CYC_TEST_BYTE_OFS;
            OP_TEST_PLAIN: n = CYC_TEST_PLAIN;
            OP_BRANCH: n = CYC_BRANCH;
            default: n = (op[7:4] == OP_BTB_HI) ? CYC_BTB : CYC_OTHER;
        endcase
        return n;
    endfunction

endpackage

// file: core/cpd_core.sv
`timescale 1ns/100ps
module cpd_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] rdata_i,
    output cpd_pkg::cpd_bus_t bus_o,
    output logic [7:0] acc_o,
    output logic [7:0] idx_o,
    output logic [7:0] flags_o,
    output logic [7:0] sp_o,
    output logic [15:0] pc_o,
    output logic fetch_o
);

    typedef enum logic [7:0] {
        ST_FETCH = 8'h01,
        ST_OPB1 = 8'h02,
        ST_OPB2 = 8'h04,
        ST_DATA = 8'h08,
        ST_PUSH = 8'h10,
        ST_VEC_HI = 8'h20,
        ST_VEC_LO = 8'h40,
        ST_PAD = 8'h80
    } cpd_state_t;

    cpd_state_t state;
    logic [7:0] op;
    logic [3:0] cyc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] vec_hi;
    logic [2:0] pidx;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [7:0] sp;
    logic [15:0] pc;
    cpd_pkg::cpd_flags_t flags;
    cpd_pkg::cpd_mode_t mode;
    logic last;
    logic [8:0] diff;

    assign mode = cpd_pkg::mode_of(op);
    assign last = (state != ST_FETCH) && (cyc == cpd_pkg::cycles_of(op) - 4'h1);
    assign acc_o = acc;
    assign idx_o = idx;
    assign flags_o = {cpd_pkg::FLAG_PAD, flags};
    assign sp_o = sp;
    assign pc_o = pc;
    assign fetch_o = state[0];

    // a minus m, with borrow in bit 8
    function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] m);
        return {1'b0, a} - {1'b0, m};
    endfunction

    // one subtractor serves both the literal and the memory operand paths
    assign diff = sub9(acc, rdata_i);

    function automatic logic [15:0] sext(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    // memory is read combinationally: the address shown in a cycle returns data in that cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_FETCH;
            op <= 8'h00;
            cyc <= 4'h0;
            b1 <= 8'h00;
            b2 <= 8'h00;
            vec_hi <= 8'h00;
            pidx <= 3'h0;
            acc <= 8'h00;
            idx <= 8'h00;
            sp <= cpd_pkg::SP_RESET;
            pc <= cpd_pkg::PC_RESET + 16'h0001;
            flags <= cpd_pkg::FLAGS_RESET;
            bus_o <= '{addr: cpd_pkg::PC_RESET, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else begin
            bus_o.rd <= 1'b0;
            bus_o.wr <= 1'b0;
            cyc <= cyc + 4'h1;
            unique case (state)
                ST_FETCH: begin
                    op <= rdata_i;
                    cyc <= 4'h1;
                    unique case (cpd_pkg::mode_of(rdata_i))
                        cpd_pkg::MD_INH: begin
                            if (rdata_i == cpd_pkg::OP_ACC_TO_IDX) idx <= acc; // RQ4
                            if (rdata_i == cpd_pkg::OP_IDX_TO_ACC) acc <= idx; // RQ5
                            if (rdata_i == cpd_pkg::OP_TEST_ACC) begin
                                flags.n <= acc[7]; // RQ6
                                flags.z <= (acc == 8'h00);
                            end
                            if (rdata_i == cpd_pkg::OP_TEST_IDX) begin
                                flags.n <= idx[7]; // RQ6
                                flags.z <= (idx == 8'h00);
                            end
                            state <= ST_PAD;
                        end
                        cpd_pkg::MD_INDEXED_PLAIN: begin
                            bus_o.addr <= {cpd_pkg::ZERO_PAGE, idx}; // RQ10
                            bus_o.rd <= 1'b1;
                            state <= ST_DATA;
                        end
                        cpd_pkg::MD_TRAP: begin
                            bus_o.addr <= {cpd_pkg::STACK_PAGE, sp}; // RQ3
                            bus_o.wr <= 1'b1;
                            bus_o.wdata <= pc[7:0];
                            sp <= sp - 8'h01;
                            pidx <= 3'h1;
                            state <= ST_PUSH;
                        end
                        cpd_pkg::MD_NONE: state <= ST_PAD;
                        default: begin
                            bus_o.addr <= pc; // RQ13
                            bus_o.rd <= 1'b1;
                            pc <= pc + 16'h0001;
                            state <= ST_OPB1;
                        end
                    endcase
                end
                ST_OPB1: begin
                    b1 <= rdata_i;
                    state <= ST_PAD;
                    unique case (mode)
                        cpd_pkg::MD_LITERAL_OPERAND: begin
                            acc <= diff[7:0]; // RQ1
                            flags.n <= diff[7]; // RQ2
                            flags.z <= (diff[7:0] == 8'h00);
                            flags.c <= diff[8];
                        end
                        cpd_pkg::MD_DIR: begin
                            bus_o.addr <= {cpd_pkg::ZERO_PAGE, rdata_i};
                            bus_o.rd <= 1'b1;
                            state <= ST_DATA;
                        end
                        cpd_pkg::MD_INDEXED_BYTE_OFFSET: begin
                            bus_o.addr <= {cpd_pkg::ZERO_PAGE, idx} + {8'h00, rdata_i}; // RQ8
                            bus_o.rd <= 1'b1;
                            state <= ST_DATA;
                        end
                        cpd_pkg::MD_REL: pc <= pc + sext(rdata_i); // RQ12
                        cpd_pkg::MD_FULL_ADDRESS, cpd_pkg::MD_INDEXED_WORD_OFFSET,
                        cpd_pkg::MD_BTB: begin
                            bus_o.addr <= pc; // RQ13
                            bus_o.rd <= 1'b1;
                            pc <= pc + 16'h0001;
                            state <= ST_OPB2;
                        end
                        default: state <= ST_PAD;
                    endcase
                end
                ST_OPB2: begin
                    b2 <= rdata_i;
                    bus_o.rd <= 1'b1;
                    state <= ST_DATA;
                    unique case (mode)
                        cpd_pkg::MD_FULL_ADDRESS: bus_o.addr <= {b1, rdata_i}; // RQ9
                        cpd_pkg::MD_INDEXED_WORD_OFFSET: begin
                            bus_o.addr <= {b1, rdata_i} + {8'h00, idx}; // RQ7
                        end
                        default: bus_o.addr <= {cpd_pkg::ZERO_PAGE, b1}; // RQ11
                    endcase
                end
                ST_DATA: begin
                    state <= ST_PAD;
                    if (mode == cpd_pkg::MD_BTB) begin
                        flags.c <= rdata_i[op[3:1]];
                        // even opcodes branch on a set bit, odd ones on a clear bit
                        if (rdata_i[op[3:1]] != op[0]) pc <= pc + sext(b2); // RQ11
                    end else if (op[7:4] >= 4'ha) begin
                        acc <= diff[7:0]; // RQ1
                        flags.n <= diff[7]; // RQ2
                        flags.z <= (diff[7:0] == 8'h00);
                        flags.c <= diff[8];
                    end else begin
                        flags.n <= rdata_i[7]; // RQ6
                        flags.z <= (rdata_i == 8'h00);
                    end
                end
                ST_PUSH: begin
                    pidx <= pidx + 3'h1;
                    if (pidx == cpd_pkg::PUSH_LAST) begin
                        flags.i <= 1'b1; // RQ3
                        bus_o.addr <= cpd_pkg::TRAP_VEC_HI;
                        bus_o.rd <= 1'b1;
                        state <= ST_VEC_HI;
                    end else begin
                        bus_o.addr <= {cpd_pkg::STACK_PAGE, sp}; // RQ3
                        bus_o.wr <= 1'b1;
                        sp <= sp - 8'h01;
                        unique case (pidx)
                            3'h1: bus_o.wdata <= pc[15:8];
                            3'h2: bus_o.wdata <= idx;
                            3'h3: bus_o.wdata <= acc;
                            default: bus_o.wdata <= {cpd_pkg::FLAG_PAD, flags};
                        endcase
                    end
                end
                ST_VEC_HI: begin
                    vec_hi <= rdata_i;
                    bus_o.addr <= cpd_pkg::TRAP_VEC_LO;
                    bus_o.rd <= 1'b1;
                    state <= ST_VEC_LO;
                end
                ST_VEC_LO: begin
                    pc <= {vec_hi, rdata_i}; // RQ3
                    state <= ST_PAD;
                end
                ST_PAD: state <= ST_PAD;
                default: state <= ST_FETCH;
            endcase
            // cycle budget reached: next opcode is addressed here, overriding the case above
            if (last) begin
                state <= ST_FETCH; // RQ2
                bus_o.addr <= pc;
                bus_o.rd <= 1'b1;
                bus_o.wr <= 1'b0;
                pc <= pc + 16'h0001;
            end
        end
    end

    a_sub_imm_time: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        fetch_o && rdata_i == 8'ha0 |-> ##1 !fetch_o ##1 fetch_o)
        else $error("literal subtract not 2 cycles");

    a_sub_result: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        fetch_o && rdata_i == 8'ha0 ##1 1'b1 |=>
        acc == $past(acc) - $past(rdata_i) && flags.c == ($past(rdata_i) > $past(acc)))
        else $error("subtract result or borrow wrong");

    a_trap_len: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        fetch_o && rdata_i == 8'h83 |=> (!fetch_o) [*8] ##2 fetch_o)
        else $error("trap not 10 cycles");

    a_trap_push: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        fetch_o && rdata_i == 8'h83 |=> bus_o.wr && bus_o.wdata == $past(pc[7:0])
        ##1 bus_o.wr && bus_o.wdata == pc[15:8] ##1 bus_o.wdata == idx
        ##4 flags.i)
        else $error("trap stacking order or mask wrong");

    a_copy_to_idx: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
        fetch_o && rdata_i == 8'h97 |=> idx == $past(acc) && $stable(flags) ##1 fetch_o)
        else $error("acc to index copy wrong");

    a_copy_to_acc: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
        fetch_o && rdata_i == 8'h9f |=> acc == $past(idx) && $stable(flags) ##1 fetch_o)
        else $error("index to acc copy wrong");

    a_test_time: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
        fetch_o && rdata_i == 8'h6d |-> ##5 fetch_o && $stable(acc))
        else $error("test byte-offset timing wrong");

    a_word_offset: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        fetch_o && rdata_i == 8'hd0 |-> ##3
        bus_o.addr == {$past(rdata_i, 2), $past(rdata_i, 1)} + {8'h00, idx})
        else $error("word offset address wrong");

    a_byte_offset: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        fetch_o && rdata_i == 8'he0 ##1 1'b1 |=>
        bus_o.rd && bus_o.addr == {8'h00, idx} + {8'h00, $past(rdata_i)})
        else $error("byte offset address wrong");

    a_full_address: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
        fetch_o && rdata_i == 8'hc0 |-> ##3 bus_o.addr == {$past(rdata_i, 2), $past(rdata_i, 1)})
        else $error("full address order wrong");

    a_plain_index: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
        fetch_o && rdata_i == 8'hf0 |=> bus_o.rd && bus_o.addr == {8'h00, idx})
        else $error("plain index address wrong");

    a_bit_test_order: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
        fetch_o && rdata_i[7:4] == 4'h0 |-> ##2 bus_o.addr == $past(bus_o.addr) + 16'h0001
        ##1 bus_o.addr == {8'h00, $past(rdata_i, 2)})
        else $error("bit test fetch order wrong");

    a_branch_target: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        fetch_o && rdata_i == 8'h20 ##1 1'b1 |=> pc == $past(pc) + sext($past(rdata_i)))
        else $error("branch target wrong");

endmodule // cpd_core

// file: dv/cpd_mem_model.sv
`timescale 1ns/100ps
module cpd_mem_model (
    input wire logic clk_i,
    input cpd_pkg::cpd_bus_t bus_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'ha5;

    // no read strobe: show a pattern that moves every cycle, never stale data
    assign rdata_o = bus_i.rd ? mem[bus_i.addr] : junk;

    always @(posedge clk_i) begin
        junk <= junk + 8'h3b;
    end

    // zero wait states: write lands at the edge that ends the cycle
    always @(posedge clk_i) begin
        if (bus_i.wr) begin
            mem[bus_i.addr] <= bus_i.wdata;
        end
    end
endmodule // cpd_mem_model

// file: dv/test_cpd_core.sv
`timescale 1ns/100ps
module test_cpd_core;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] rdata;
    cpd_pkg::cpd_bus_t bus;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [7:0] flags;
    logic [7:0] sp;
    logic [15:0] pc;
    logic fetch;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;

    cpd_core i_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rdata_i(rdata),
        .bus_o(bus),
        .acc_o(acc),
        .idx_o(idx),
        .flags_o(flags),
        .sp_o(sp),
        .pc_o(pc),
        .fetch_o(fetch)
    );

    cpd_mem_model i_mem (
        .clk_i(clk_i),
        .bus_i(bus),
        .rdata_o(rdata)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole program runs in well under this; a hang ends here
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 400) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // up to three bytes, left aligned in b
    task automatic ld(input logic [15:0] a, input logic [23:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            i_mem.mem[a + 16'(i)] = b[23 - 8 * i -: 8];
        end
    endtask

    // from an opcode fetch cycle, run to the next fetch and judge the state
    task automatic exec(input int n, input logic [15:0] nxt, input logic [7:0] a,
            input logic [7:0] x, input logic [7:0] f);
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (fetch !== 1'b1 && k < 20);
        chk(16'(k), 16'(n), "cycles");
        chk(bus.addr, nxt, "fetch address");
        chk(pc, nxt + 16'h0001, "program counter");
        chk({8'h00, acc}, {8'h00, a}, "accumulator");
        chk({8'h00, idx}, {8'h00, x}, "index");
        chk({8'h00, flags}, {8'h00, f}, "flags");
    endtask

    task automatic t_reset();
        repeat (2) @(negedge clk_i);
        chk({8'h00, sp}, 16'h00ff, "reset stack");
        chk({8'h00, flags}, 16'h00e8, "reset flags");
        chk(pc, 16'h0001, "reset pc");
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({15'h0000, fetch}, 16'h0001, "first fetch");
        chk(bus.addr, 16'h0000, "first address");
        $display("test reset done");
    endtask

    task automatic t_xfer();
        exec(2, 16'h0002, 8'hfb, 8'h00, 8'hed);
        exec(2, 16'h0003, 8'hfb, 8'hfb, 8'hed);
        exec(3, 16'h0005, 8'h00, 8'hfb, 8'hea);
        exec(2, 16'h0006, 8'hfb, 8'hfb, 8'hea);
        $display("test transfers done");
    endtask

    task automatic t_sub();
        exec(4, 16'h0009, 8'hfa, 8'hfb, 8'hec);
        exec(5, 16'h000c, 8'h00, 8'hfb, 8'hea);
        exec(4, 16'h000e, 8'hff, 8'hfb, 8'hed);
        exec(3, 16'h000f, 8'hf0, 8'hfb, 8'hec);
        $display("test subtract modes done");
    endtask

    task automatic t_test();
        exec(4, 16'h0011, 8'hf0, 8'hfb, 8'he8);
        exec(3, 16'h0012, 8'hf0, 8'hfb, 8'hec);
        exec(3, 16'h0013, 8'hf0, 8'hfb, 8'hec);
        exec(5, 16'h0015, 8'hf0, 8'hfb, 8'hea);
        exec(4, 16'h0016, 8'hf0, 8'hfb, 8'he8);
        $display("test zero test done");
    endtask

    task automatic t_branch();
        exec(3, 16'h001a, 8'hf0, 8'hfb, 8'he8);
        exec(5, 16'h001d, 8'hf0, 8'hfb, 8'he9);
        exec(5, 16'h0022, 8'hf0, 8'hfb, 8'he9);
        $display("test branches done");
    endtask

    task automatic t_trap();
        exec(10, 16'h0200, 8'hf0, 8'hfb, 8'he9);
        chk({8'h00, sp}, 16'h00fa, "stack after trap");
        chk({8'h00, i_mem.mem[16'h00ff]}, 16'h0023, "pushed pc low");
        chk({8'h00, i_mem.mem[16'h00fe]}, 16'h0000, "pushed pc high");
        chk({8'h00, i_mem.mem[16'h00fd]}, 16'h00fb, "pushed index");
        chk({8'h00, i_mem.mem[16'h00fc]}, 16'h00f0, "pushed acc");
        chk({8'h00, i_mem.mem[16'h00fb]}, 16'h00e9, "pushed flags");
        $display("test trap done");
    endtask

    initial begin
        ld(16'h0000, 24'ha00597, 3);
        ld(16'h0003, 24'hb0109f, 3);
        ld(16'h0006, 24'hc01234, 3);
        ld(16'h0009, 24'hd00100, 3);
        ld(16'h000c, 24'he002f0, 3);
        ld(16'h000f, 24'h3d104d, 3);
        ld(16'h0012, 24'h5d6d05, 3);
        ld(16'h0015, 24'h7d2002, 3);
        ld(16'h001a, 24'h011002, 3);
        ld(16'h001d, 24'h001002, 3);
        ld(16'h0022, 24'h830000, 1);
        ld(16'h0010, 24'hfb0000, 1);
        ld(16'h1234, 24'h010000, 1);
        ld(16'h01fb, 24'hfa0000, 1);
        ld(16'h00fd, 24'h010000, 1);
        ld(16'h00fb, 24'h0f0000, 1);
        ld(16'h0100, 24'h000000, 1);
        ld(16'hfffc, 24'h02009f, 3);
        ld(16'h0200, 24'h9f9f9f, 3);
        t_reset();
        t_xfer();
        t_sub();
        t_test();
        t_branch();
        t_trap();
        close_out();
    end
endmodule // test_cpd_core
